// ===== src/bbs_pkg.sv
// constants and types shared by the switch protection controller
package bbs_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

	// leading-edge blanking length; plain default, trim per process
	localparam int LEB_NS = 300;
	localparam int LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
	// maximum on-time, a longest time: rounds down
	localparam int TON_MAX_NS = 14_500;
	localparam int TON_MAX_CYC = TON_MAX_NS / CLK_NS;
	// maximum off-time, keeps the switching rate from falling below about 18 kHz
	localparam int TOFF_MAX_NS = 40_000;
	localparam int TOFF_MAX_CYC = TOFF_MAX_NS / CLK_NS;
	// ringing suppression at the start of the freewheel stroke, a least time: rounds up
	localparam int RING_NS = 1_450;
	localparam int RING_CYC = (RING_NS + RING_NS * 0 + CLK_NS - 1) / CLK_NS;
	localparam int OVP_CYCLES = 3;
	localparam int CNT_W = 16;

	// comparator bit positions on the synchronised bus
	localparam int CMP_TRIP = 0;
	localparam int CMP_MIN = 1;
	localparam int CMP_TEND = 2;
	localparam int CMP_DEMAG = 3;
	localparam int CMP_VALLEY = 4;
	localparam int CMP_OVP = 5;
	localparam int CMP_START = 6;
	localparam int CMP_STOP = 7;
	localparam int CMP_RST = 8;
	localparam int CMP_OT = 9;
	localparam int CMP_N = 10;

	// values after reset
	localparam logic RST_ENABLED = 1'b0;
	localparam logic RST_GATE = 1'b0;
	localparam logic RST_DCH = 1'b0;
	localparam logic RST_LOW_MAINS = 1'b0;

	typedef enum logic [2:0] {
		BBS_IDLE = 3'h0,
		BBS_ON = 3'h1,
		BBS_FREE = 3'h3,
		BBS_WAIT = 3'h2,
		BBS_DISCH = 3'h6
	} bbs_state_t;
endpackage

// ===== src/bbs_cmp_if.sv
// raw and filtered comparator levels between the core and its input filter
`timescale 1ns/1ps
interface bbs_cmp_if #(
	parameter int W = 10
);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport core (output raw, input clean);
endinterface

// ===== src/bbs_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bbs_sync
	import bbs_pkg::*;
#(
	parameter int W = 10
) (
	input wire logic clock,
	input wire logic reset,
	bbs_cmp_if.filt cmp
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} bbs_sync_t;

	bbs_sync_t s;
	bbs_sync_t next_s;

	// s1 feeds only s2; the agreement check looks at s2 and s3
	always_comb begin
		next_s = s;
		next_s.s1 = cmp.raw;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		for (int i = 0; i < W; i++) begin
			if (s.s2[i] == s.s3[i]) begin
				next_s.out[i] = s.s3[i];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign cmp.clean = s.out;
endmodule // bbs_sync

// ===== src/bbs_ctrl.sv
// switching-cycle sequencer and protection core of the buck-boost LED converter
// Notes on behaviour
// - after each turn-on ignore the peak comparator until blanking ends
// - after blanking, a peak trip turns the switch off this cycle
// - on-phase never lasts beyond the fixed maximum on-time
// - at low mains stretch the off-phase to the maximum off-time
// - a cycle whose peak stays under the minimum level marks low mains
// - supply below stop level stops switching at once
// - after a supply stop, switching resumes only after supply passes the start-up level
// - over-temperature stops switching; resumes when the flag clears
// - overvoltage comparator sampled only during the freewheel stroke
// - count consecutive overvoltage cycles, clear on a clean one, trip at three
// - on trip stop, discharge supply to reset level, then fresh start-up
// - no turn-on until the previous freewheel stroke has ended
// - turn on after demagnetization is seen low and a valley follows
// - ignore demagnetization comparator during ringing blanking at freewheel start
// - the ringing blanking lasts nominally 1.45 microseconds
// - the overvoltage filter needs 3 consecutive cycles by default
`timescale 1ns/1ps
module bbs_ctrl
	import bbs_pkg::*;
#(
	parameter int OVP_N = OVP_CYCLES,
	parameter int OVP_W = $clog2(OVP_N + 1)
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic peak_trip_level_cmp,
	input wire logic min_sense_peak_cmp,
	input wire logic on_time_end,
	input wire logic demag_low_cmp,
	input wire logic valley_detect,
	input wire logic overvolt_cmp,
	input wire logic supply_start_cmp,
	input wire logic supply_stop_level_cmp,
	input wire logic supply_reset_cmp,
	input wire logic overtemp_flag,
	output logic power_switch_gate,
	output logic supply_discharge_current,
	output logic low_mains_mode,
	output logic peak_current_trip,
	output logic switching_active
);
	typedef struct packed {
		bbs_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [OVP_W-1:0] ovp_cnt;
		logic enabled;
		logic peak_seen;
		logic low_mains;
		logic ovp_seen;
		logic gate;
		logic dch;
		logic trip;
	} bbs_ctrl_t;

	localparam logic [CNT_W-1:0] LEB_C = CNT_W'(LEB_CYC);
	localparam logic [CNT_W-1:0] TON_C = CNT_W'(TON_MAX_CYC);
	localparam logic [CNT_W-1:0] TOFF_C = CNT_W'(TOFF_MAX_CYC);
	localparam logic [CNT_W-1:0] RING_C = CNT_W'(RING_CYC);
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [OVP_W-1:0] OVP_LAST = OVP_W'(OVP_N - 1);

	bbs_cmp_if #(.W(CMP_N)) cmp ();

	assign cmp.raw[CMP_TRIP] = peak_trip_level_cmp;
	assign cmp.raw[CMP_MIN] = min_sense_peak_cmp;
	assign cmp.raw[CMP_TEND] = on_time_end;
	assign cmp.raw[CMP_DEMAG] = demag_low_cmp;
	assign cmp.raw[CMP_VALLEY] = valley_detect;
	assign cmp.raw[CMP_OVP] = overvolt_cmp;
	assign cmp.raw[CMP_START] = supply_start_cmp;
	assign cmp.raw[CMP_STOP] = supply_stop_level_cmp;
	assign cmp.raw[CMP_RST] = supply_reset_cmp;
	assign cmp.raw[CMP_OT] = overtemp_flag;

	// all comparators are asynchronous to the timing clock
	bbs_sync #(.W(CMP_N)) u_sync (
		.clock(clock),
		.reset(reset),
		.cmp(cmp.filt)
	);

	logic [CMP_N-1:0] c;
	assign c = cmp.clean;

	bbs_ctrl_t s;
	bbs_ctrl_t next_s;
	logic leb_done;
	logic ring_done;
	logic ton_last;
	logic toff_last;
	logic [CNT_W-1:0] cnt_inc;

	assign leb_done = s.cnt >= LEB_C;
	assign ring_done = s.cnt >= RING_C;
	assign ton_last = s.cnt >= TON_C - 1'b1;
	assign toff_last = s.cnt >= TOFF_C - 1'b1;
	// saturating, so a very long demagnetization never wraps the off timer
	assign cnt_inc = (s.cnt == CNT_MAX) ? s.cnt : s.cnt + 1'b1;

	always_comb begin
		next_s = s;
		next_s.trip = 1'b0;
		case (s.st)
			BBS_IDLE: begin
				next_s.gate = 1'b0;
				next_s.dch = 1'b0;
				if (!s.enabled) begin
					if (c[CMP_START] && !c[CMP_STOP]) begin
						next_s.enabled = 1'b1;
					end
				end else if (!c[CMP_OT]) begin
					next_s.st = BBS_ON;
					next_s.gate = 1'b1;
					next_s.cnt = '0;
					next_s.peak_seen = 1'b0;
				end
			end
			BBS_ON: begin
				next_s.cnt = cnt_inc;
				next_s.peak_seen = s.peak_seen | c[CMP_MIN];
				// trip ignored inside the blanking window
				if ((leb_done && c[CMP_TRIP]) || c[CMP_TEND] || ton_last) begin
					next_s.st = BBS_FREE;
					next_s.gate = 1'b0;
					next_s.cnt = '0;
					next_s.trip = leb_done && c[CMP_TRIP];
					next_s.low_mains = !(s.peak_seen | c[CMP_MIN]);
					next_s.ovp_seen = 1'b0;
				end
			end
			BBS_FREE: begin
				next_s.cnt = cnt_inc;
				if (c[CMP_OVP]) begin
					next_s.ovp_seen = 1'b1;
				end
				// ringing right after turn-off would fake the end of the stroke
				if (ring_done && c[CMP_DEMAG]) begin
					next_s.st = BBS_WAIT;
					if (s.ovp_seen || c[CMP_OVP]) begin
						if (s.ovp_cnt >= OVP_LAST) begin
							next_s.st = BBS_DISCH;
							next_s.dch = 1'b1;
							next_s.enabled = 1'b0;
							next_s.ovp_cnt = '0;
						end else begin
							next_s.ovp_cnt = s.ovp_cnt + 1'b1;
						end
					end else begin
						next_s.ovp_cnt = '0;
					end
				end
			end
			BBS_WAIT: begin
				next_s.cnt = cnt_inc;
				// low mains skips the valley and waits out the whole off-time
				if ((c[CMP_VALLEY] && !s.low_mains) || toff_last) begin
					next_s.st = BBS_ON;
					next_s.gate = 1'b1;
					next_s.cnt = '0;
					next_s.peak_seen = 1'b0;
				end
			end
			BBS_DISCH: begin
				next_s.gate = 1'b0;
				next_s.dch = 1'b1;
				if (c[CMP_RST]) begin
					next_s.st = BBS_IDLE;
					next_s.dch = 1'b0;
				end
			end
			default: begin
				next_s.st = BBS_IDLE;
				next_s.gate = 1'b0;
				next_s.dch = 1'b0;
			end
		endcase
		// an overvoltage trip taken this cycle keeps its discharge, stop or not
		if (s.st != BBS_DISCH && next_s.st != BBS_DISCH) begin
			if (c[CMP_STOP]) begin
				next_s.st = BBS_IDLE;
				next_s.enabled = 1'b0;
				next_s.gate = 1'b0;
			end else if (c[CMP_OT] && s.st != BBS_IDLE) begin
				next_s.st = BBS_IDLE;
				next_s.gate = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s <= '0;
			s.st <= BBS_IDLE;
			s.enabled <= RST_ENABLED;
			s.gate <= RST_GATE;
			s.dch <= RST_DCH;
			s.low_mains <= RST_LOW_MAINS;
		end else begin
			s <= next_s;
		end
	end

	assign power_switch_gate = s.gate;
	assign supply_discharge_current = s.dch;
	assign low_mains_mode = s.low_mains;
	assign peak_current_trip = s.trip;
	assign switching_active = s.enabled;

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (reset);

	leb_guard_a: assert property (
		s.st == BBS_ON && !leb_done && !ton_last && !c[CMP_TEND] && !c[CMP_STOP]
			&& !c[CMP_OT] |=> s.gate)
		else $error("peak comparator acted inside blanking");

	peak_off_a: assert property (
		s.st == BBS_ON && leb_done && c[CMP_TRIP] |=> !s.gate && s.trip)
		else $error("peak trip did not end the on-phase");

	ton_max_a: assert property (
		s.gate |-> s.cnt < TON_C)
		else $error("on-phase exceeded maximum on-time");

	toff_stretch_a: assert property (
		s.st == BBS_WAIT && s.low_mains && !toff_last |=> !s.gate)
		else $error("low mains off-phase ended before maximum off-time");

	low_mains_a: assert property (
		s.st == BBS_ON && next_s.st == BBS_FREE
			|=> s.low_mains == !$past(s.peak_seen | c[CMP_MIN]))
		else $error("low mains flag wrong after cycle");

	stop_now_a: assert property (
		c[CMP_STOP] && s.st != BBS_DISCH |=> !s.gate && !s.enabled)
		else $error("switching continued below stop level");

	start_level_a: assert property (
		$rose(s.enabled) |-> $past(c[CMP_START]))
		else $error("restart without start-up level");

	overtemp_a: assert property (
		c[CMP_OT] |=> !s.gate)
		else $error("switching during over-temperature");

	ovp_trip_a: assert property (
		s.st == BBS_FREE && next_s.st == BBS_DISCH |-> s.ovp_cnt == OVP_LAST)
		else $error("overvoltage trip at wrong count");

	dch_hold_a: assert property (
		s.st == BBS_DISCH && !c[CMP_RST] |=> s.dch && !s.gate && s.st == BBS_DISCH)
		else $error("discharge left before reset level");

	no_free_on_a: assert property (
		s.st == BBS_FREE |=> !s.gate)
		else $error("turn-on during freewheel stroke");

	ring_blank_a: assert property (
		s.st == BBS_FREE && !ring_done |=> s.st != BBS_WAIT)
		else $error("demagnetization taken during ringing blanking");

	ovp_window_a: assert property (
		!s.ovp_seen && s.st != BBS_FREE |=> !s.ovp_seen)
		else $error("overvoltage taken outside the freewheel stroke");

	ovp_clear_a: assert property (
		s.st == BBS_FREE && ring_done && c[CMP_DEMAG] && !s.ovp_seen && !c[CMP_OVP]
			|=> s.ovp_cnt == '0)
		else $error("overvoltage count kept after a clean cycle");

	dch_only_a: assert property (
		s.dch |-> s.st == BBS_DISCH)
		else $error("discharge outside the discharge state");

	hyst_hold_a: assert property (
		!s.enabled && !c[CMP_START] |=> !s.enabled)
		else $error("enabled below the start-up level");

	valley_on_a: assert property (
		s.st == BBS_WAIT && c[CMP_VALLEY] && !s.low_mains && !c[CMP_STOP] && !c[CMP_OT]
			|=> s.gate && s.st == BBS_ON)
		else $error("valley did not start a cycle");

	toff_expire_a: assert property (
		s.st == BBS_WAIT && toff_last && !c[CMP_STOP] && !c[CMP_OT] |=> s.gate)
		else $error("off-time expiry did not start a cycle");

	off_restart_a: assert property (
		$fell(s.gate) && s.st == BBS_FREE |-> s.cnt == '0)
		else $error("off timer not restarted at turn-off");

	trip_pulse_a: assert property (
		s.trip |=> !s.trip)
		else $error("peak trip held beyond one cycle");

	valley_on_c: cover property (s.st == BBS_WAIT && c[CMP_VALLEY] && !s.low_mains ##1 s.gate);
	toff_on_c: cover property (s.st == BBS_WAIT && s.low_mains && toff_last ##1 s.gate);
	ovp_trip_c: cover property (s.st == BBS_FREE ##1 s.st == BBS_DISCH);
	peak_trip_c: cover property (s.trip);
	tend_end_c: cover property (s.st == BBS_ON && c[CMP_TEND] ##1 !s.gate);
endmodule // bbs_ctrl

// ===== dv/bbs_stage.sv
// power stage model: inductor ramp, demagnetisation, valley and overvoltage sense
`timescale 1ns/1ps
module bbs_stage (
	input wire logic clock,
	input wire logic gate,
	input wire logic [8:0] t_pk,
	input wire logic [8:0] t_dm,
	input wire logic low,
	input wire logic ovp_en,
	output logic peak,
	output logic minpk,
	output logic demag,
	output logic valley,
	output logic ovp
);
	logic g_d = 1'b0;
	logic [8:0] n = 9'h000;
	// phase timer saturates so a long idle never fakes a new stroke
	always_ff @(posedge clock) begin
		g_d <= gate;
		n <= (gate != g_d) ? 9'h000 : n + {8'h00, n != 9'h1FF};
	end
	assign peak = gate && !low && n >= t_pk;
	assign minpk = !low;
	assign demag = !gate && n >= t_dm;
	// valley stays offered in low mains too, the block must skip it there
	assign valley = demag && n >= t_dm + 9'h002;
	assign ovp = !gate && !demag && ovp_en;
endmodule // bbs_stage

// ===== dv/tb.sv
// self-checking bench for the switch protection controller
`timescale 1ns/1ps
module tb;
	import bbs_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic stop = 1'b0;
	logic rstl = 1'b0;
	logic ot = 1'b0;
	logic low = 1'b0;
	logic ovp_en = 1'b0;
	logic tend = 1'b0;
	logic [8:0] t_pk = 9'h00A;
	logic [8:0] t_dm = 9'h01E;
	logic peak, minpk, demag, valley, ovp, gate, dch, lm, trip, act;
	logic g_q = 1'b0;
	int n_fail = 0;
	int total_checks = 0;
	int n_on = 0;
	int n_trip = 0;
	int cyc_n = 0;
	int w;
	int k;

	initial begin
		forever #50 clock = ~clock;
	end

	bbs_stage stage (.clock(clock), .gate(gate), .t_pk(t_pk), .t_dm(t_dm), .low(low),
		.ovp_en(ovp_en), .peak(peak), .minpk(minpk), .demag(demag), .valley(valley), .ovp(ovp));

	bbs_ctrl DUT (.clock(clock), .reset(reset), .peak_trip_level_cmp(peak),
		.min_sense_peak_cmp(minpk), .on_time_end(tend), .demag_low_cmp(demag),
		.valley_detect(valley), .overvolt_cmp(ovp), .supply_start_cmp(start),
		.supply_stop_level_cmp(stop), .supply_reset_cmp(rstl), .overtemp_flag(ot),
		.power_switch_gate(gate), .supply_discharge_current(dch), .low_mains_mode(lm),
		.peak_current_trip(trip), .switching_active(act));

	// outputs are looked at on the falling edge, well clear of the update edge
	always @(negedge clock) begin
		g_q <= gate;
		if (gate === 1'b1 && g_q === 1'b0) n_on++;
		if (trip === 1'b1) n_trip++;
	end

	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 60000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int m);
		repeat (m) @(negedge clock);
	endtask

	// waits for gate at lvl, then returns how many cycles it stays there
	task automatic pulse(input logic lvl, output int len);
		k = 0;
		while (gate !== lvl && k < 2000) begin
			@(negedge clock);
			k++;
		end
		len = 0;
		while (gate === lvl && len < 2000) begin
			@(negedge clock);
			len++;
		end
	endtask

	task automatic t_start;
		cyc(50);
		check("idle gate", gate, 1'b0);
		@(posedge clock) start <= 1'b1;
		pulse(1'b0, w);
		check("active", act, 1'b1);
	endtask

	task automatic t_peak;
		n_trip = 0;
		pulse(1'b1, w);
		pulse(1'b1, w);
		check("trip width", w >= 10 && w <= 16, 1'b1);
		check("trip pulse", n_trip >= 1, 1'b1);
		pulse(1'b0, w);
		check("off width", w >= 30 && w <= 42, 1'b1);
		check("mains", lm, 1'b0);
	endtask

	task automatic t_ring;
		@(posedge clock) t_dm <= 9'h002;
		pulse(1'b0, w);
		pulse(1'b0, w);
		check("ring blank", w >= RING_CYC, 1'b1);
		@(posedge clock) t_dm <= 9'h01E;
	endtask

	task automatic t_ton;
		@(posedge clock) t_pk <= 9'h190;
		pulse(1'b1, w);
		pulse(1'b1, w);
		check("max on", w, 16'(TON_MAX_CYC));
		@(posedge clock) t_pk <= 9'h00A;
	endtask

	task automatic t_tend;
		@(posedge clock) tend <= 1'b1;
		pulse(1'b1, w);
		pulse(1'b1, w);
		check("end on", w, 16'h0001);
		@(posedge clock) tend <= 1'b0;
	endtask

	task automatic t_low;
		@(posedge clock) low <= 1'b1;
		pulse(1'b0, w);
		pulse(1'b0, w);
		check("low mains", lm, 1'b1);
		check("max off", w >= TOFF_MAX_CYC - 1 && w <= TOFF_MAX_CYC + 2, 1'b1);
		@(posedge clock) low <= 1'b0;
		pulse(1'b0, w);
	endtask

	task automatic t_ovp;
		pulse(1'b0, w);
		@(posedge clock) ovp_en <= 1'b1;
		n_on = 0;
		k = 0;
		while (dch !== 1'b1 && k < 2000) begin
			@(negedge clock);
			k++;
		end
		check("ovp cycles", n_on, 16'(OVP_CYCLES - 1));
		check("ovp stop", {gate, act}, 2'h0);
		cyc(20);
		check("dch hold", dch, 1'b1);
		@(posedge clock) ovp_en <= 1'b0;
		start <= 1'b0;
		rstl <= 1'b1;
		cyc(30);
		check("dch end", {dch, gate}, 2'h0);
		@(posedge clock) rstl <= 1'b0;
		start <= 1'b1;
		pulse(1'b0, w);
		check("restart", act, 1'b1);
	endtask

	task automatic t_lockout;
		pulse(1'b0, w);
		@(posedge clock) stop <= 1'b1;
		start <= 1'b0;
		cyc(6);
		check("lockout", {gate, act}, 2'h0);
		@(posedge clock) stop <= 1'b0;
		cyc(30);
		check("hysteresis", gate, 1'b0);
		@(posedge clock) start <= 1'b1;
		pulse(1'b0, w);
		check("resume", act, 1'b1);
	endtask

	task automatic t_ot;
		pulse(1'b0, w);
		@(posedge clock) ot <= 1'b1;
		cyc(8);
		check("hot stop", gate, 1'b0);
		check("hot active", act, 1'b1);
		cyc(40);
		check("hot idle", gate, 1'b0);
		@(posedge clock) ot <= 1'b0;
		pulse(1'b0, w);
		check("hot resume", gate, 1'b1);
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		t_start();
		t_peak();
		t_ring();
		t_ton();
		t_tend();
		t_low();
		t_ovp();
		t_lockout();
		t_ot();
		end_of_test();
	end
endmodule // tb
